// ### rtl/rclk_consts.svh
// constants of the reclocker control logic: offsets, fields, resets, timing
`ifndef RCLK_CONSTS_SVH
`define RCLK_CONSTS_SVH
`define RCLK_OFF_CTRL 8'h00
`define RCLK_OFF_STAT 8'h04
`define RCLK_OFF_RATE 8'h08
`define RCLK_CTRL_SEL_LSB 0
`define RCLK_CTRL_MUTE_N 2
`define RCLK_CTRL_FORCE 3
`define RCLK_CTRL_AUXCLK 4
`define RCLK_CTRL_MUTE_FROM_LOCK 5
`define RCLK_CTRL_RESET 32'h0000_0004
`define RCLK_RATE_RESET 32'h0000_0001
`define RCLK_STAT_LOCK 0
`define RCLK_STAT_STD 1
`define RCLK_STAT_BYPASS 2
`define RCLK_STAT_MUTED 3
`define RCLK_CLK_MHZ 125
`define RCLK_REF_NS 37
`define RCLK_REF_CYC ((`RCLK_REF_NS * `RCLK_CLK_MHZ + 999) / 1000)
`define RCLK_LOSS_US 1000
`define RCLK_LOSS_CYC ((`RCLK_LOSS_US * `RCLK_CLK_MHZ))
`define RCLK_ACQ_US 15000
`define RCLK_ACQ_CYC ((`RCLK_ACQ_US * `RCLK_CLK_MHZ))
`define RCLK_RESP_OKAY 2'b00
`define RCLK_RESP_SLVERR 2'b10
`endif

// ### rtl/rclk_pkg.sv
// types of the reclocker control logic
`default_nettype none
package rclk_pkg;
  typedef enum logic [1:0] {
    RCLK_PATH_RETIME = 2'b00,
    RCLK_PATH_BYPASS = 2'b01,
    RCLK_PATH_MUTE = 2'b10
  } rclk_path_type;
  typedef enum logic [1:0] {
    RCLK_LK_IDLE = 2'b00,
    RCLK_LK_ACQ = 2'b01,
    RCLK_LK_LOCKED = 2'b10
  } rclk_lock_type;
endpackage
`default_nettype wire

// ### rtl/rclk_ctl_if.sv
// bundle between the register slave and the control core
`timescale 1ns/1ns
`default_nettype none
interface rclk_ctl_if;
  logic [31:0] ctrl;
  logic [31:0] stat;
  logic [31:0] rate_cfg;
  modport regs (output ctrl, output rate_cfg, input stat);
  modport core (input ctrl, input rate_cfg, output stat);
endinterface
`default_nettype wire

// ### rtl/rclk_axil_regs.sv
// axi4-lite slave holding control and rate registers and reading back status from the core
`timescale 1ns/1ns
`default_nettype none
`include "rclk_consts.svh"
module rclk_axil_regs
  import rclk_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  rclk_ctl_if.regs ctl
);
  logic [7:0] aw_reg;
  logic aw_have_reg;
  logic [31:0] w_reg;
  logic [3:0] s_reg;
  logic w_have_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] rate_reg;

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // next holding and answer state, so that the ready flags can sit in flops
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;
  logic rvalid_next;
  assign bvalid_next = (aw_have_reg && w_have_reg) || (bvalid && !bready);
  assign aw_have_next = !(aw_have_reg && w_have_reg) && (aw_have_reg || (awvalid && awready));
  assign w_have_next = !(aw_have_reg && w_have_reg) && (w_have_reg || (wvalid && wready));
  assign rvalid_next = (arvalid && arready) || (rvalid && !rready);

  // registered ready flags: each open only while its own channel holds nothing and no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      awready <= !aw_have_next && !bvalid_next;
      wready <= !w_have_next && !bvalid_next;
      arready <= !rvalid_next;
    end
  end
  assign ctl.ctrl = ctrl_reg;
  assign ctl.rate_cfg = rate_reg;

  // write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_reg <= 8'h00;
      w_reg <= 32'h0000_0000;
      s_reg <= 4'h0;
    end else if (aw_have_reg && w_have_reg) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_reg <= wdata;
        s_reg <= wstrb;
      end
    end
  end

  // register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `RCLK_CTRL_RESET;
      rate_reg <= `RCLK_RATE_RESET;
      bvalid <= 1'b0;
      bresp <= `RCLK_RESP_OKAY;
    end else if (aw_have_reg && w_have_reg) begin
      bvalid <= 1'b1;
      bresp <= `RCLK_RESP_OKAY;
      case (aw_reg)
        `RCLK_OFF_CTRL: ctrl_reg <= merge(ctrl_reg, w_reg, s_reg) & 32'h0000_003F;
        `RCLK_OFF_RATE: rate_reg <= merge(rate_reg, w_reg, s_reg) & 32'h0000_0001;
        `RCLK_OFF_STAT: bresp <= `RCLK_RESP_OKAY;
        default: bresp <= `RCLK_RESP_SLVERR;
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RCLK_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RCLK_RESP_OKAY;
      case (araddr)
        `RCLK_OFF_CTRL: rdata <= ctrl_reg;
        `RCLK_OFF_STAT: rdata <= ctl.stat;
        `RCLK_OFF_RATE: rdata <= rate_reg;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RCLK_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/rclk_top.sv
// control and indicator logic of the serial video reclocker
//
// What this block does
// - two-bit code picks one of four inputs
// - lock high only with data, after loop lock or the acquisition time
// - forced passthrough holds lock indicator low
// - mute low silences both outputs
// - mute wins over bypass
// - mute input defaults inactive high
// - forced passthrough passes data unretimed
// - auto bypass when unlocked or unsupported rate
// - forced passthrough defaults low
// - unmuted: lock low bypasses, lock high retimes at a supported rate
// - lock tied to mute mutes when unlocked
// - standard indicator high at 270 Mbps
// - standard indicator registered, valid when locked
// - standard indicator valid one reference period later
// - no data transition for 1 ms drops lock
// - standard indicator low while unlocked
// - aux select high gives clock, else data
// - select bits default to input 0
// - lock within 15 ms of first transition
// - aux clock muted during bypass
// - muted output static, legs opposite
// - aux clock edge centred in bit
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rclk_consts.svh"
module rclk_top
  import rclk_pkg::*;
#(
  parameter int unsigned LOSS_CYC = `RCLK_LOSS_CYC,
  parameter int unsigned ACQ_CYC = `RCLK_ACQ_CYC
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in_0,
  input wire logic serial_in_1,
  input wire logic serial_in_2,
  input wire logic serial_in_3,
  input wire logic recovered_clk,
  input wire logic recovered_data,
  input wire logic loop_locked,
  output logic lock_indicator,
  output logic std_rate_indicator,
  output logic primary_serial_out,
  output logic primary_serial_out_n,
  output logic aux_serial_out,
  output logic aux_serial_out_n,
  output logic selected_raw
);
  localparam int unsigned REF_CYC = `RCLK_REF_CYC;

  // refuse counts that the lock and settle counters cannot serve
  if (LOSS_CYC < 2 || ACQ_CYC < 2 || REF_CYC < 1 || REF_CYC > 255) begin : g_bad_counts
    $error("rclk_top: LOSS_CYC, ACQ_CYC need 2 or more, settle count 1 to 255");
  end

  rclk_ctl_if ctl();

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  rclk_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .ctl(ctl.regs)
  );

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  logic [1:0] sel;
  logic mute_n;
  logic force_bypass;
  logic aux_clk_mode;
  logic mute_from_lock;
  logic rate_ok;
  assign sel = ctl.ctrl[`RCLK_CTRL_SEL_LSB +: 2];
  assign mute_n = ctl.ctrl[`RCLK_CTRL_MUTE_N];
  assign force_bypass = ctl.ctrl[`RCLK_CTRL_FORCE];
  assign aux_clk_mode = ctl.ctrl[`RCLK_CTRL_AUXCLK];
  assign mute_from_lock = ctl.ctrl[`RCLK_CTRL_MUTE_FROM_LOCK];
  assign rate_ok = ctl.rate_cfg[0];

  // input chooser function
  function automatic logic pick(input logic [1:0] s, input logic [3:0] d);
    case (s)
      2'b00: pick = d[0];
      2'b01: pick = d[1];
      2'b10: pick = d[2];
      2'b11: pick = d[3];
      default: pick = d[0];
    endcase
  endfunction

  logic chosen;
  assign chosen = pick(sel, {serial_in_3, serial_in_2, serial_in_1, serial_in_0});

  // ----------------------------------------------------------------
  // lock tracking
  // ----------------------------------------------------------------
  rclk_lock_type lk_reg;
  logic [31:0] acq_cnt_reg;
  logic [31:0] idle_cnt_reg;
  logic prev_in_reg;
  logic [1:0] prev_sel_reg;
  logic edge_seen;
  assign edge_seen = (chosen != prev_in_reg) && (sel == prev_sel_reg);

  // remember last sample and select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_in_reg <= 1'b0;
      prev_sel_reg <= 2'b00;
    end else begin
      prev_in_reg <= chosen;
      prev_sel_reg <= sel;
    end
  end

  // lock state machine: idle, acquiring, locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_reg <= RCLK_LK_IDLE;
      acq_cnt_reg <= 32'h0000_0000;
      idle_cnt_reg <= 32'h0000_0000;
    end else if (sel != prev_sel_reg || force_bypass) begin
      lk_reg <= RCLK_LK_IDLE;
      acq_cnt_reg <= 32'h0000_0000;
      idle_cnt_reg <= 32'h0000_0000;
    end else begin
      idle_cnt_reg <= edge_seen ? 32'h0000_0000 : idle_cnt_reg + 32'h0000_0001;
      case (lk_reg)
        RCLK_LK_IDLE: begin
          if (edge_seen) begin
            lk_reg <= RCLK_LK_ACQ;
            acq_cnt_reg <= 32'h0000_0000;
          end
        end
        RCLK_LK_ACQ: begin
          acq_cnt_reg <= acq_cnt_reg + 32'h0000_0001;
          if (idle_cnt_reg >= LOSS_CYC - 1) begin
            lk_reg <= RCLK_LK_IDLE;
          end else if (loop_locked || acq_cnt_reg >= ACQ_CYC - 2) begin
            lk_reg <= RCLK_LK_LOCKED;
          end
        end
        RCLK_LK_LOCKED: begin
          if (idle_cnt_reg >= LOSS_CYC - 1) begin
            lk_reg <= RCLK_LK_IDLE;
          end
        end
        default: lk_reg <= RCLK_LK_IDLE;
      endcase
    end
  end

  // next lock value; the rate indicator watches it so that both change on one edge
  // and the rate indicator never lags a falling lock
  logic lock_next;
  assign lock_next = (lk_reg == RCLK_LK_LOCKED) && !force_bypass;

  // lock indicator, low from the edge after forced passthrough is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_indicator <= 1'b0;
    end else begin
      lock_indicator <= lock_next;
    end
  end

  // ----------------------------------------------------------------
  // standard rate indicator, settles one reference period after lock edge
  // ----------------------------------------------------------------
  logic [7:0] ref_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_reg <= 8'h00;
      std_rate_indicator <= 1'b0;
    end else begin
      if (lock_next != lock_indicator) begin
        ref_cnt_reg <= REF_CYC[7:0] - 8'h01;
        std_rate_indicator <= 1'b0;
      end else if (ref_cnt_reg != 8'h00) begin
        ref_cnt_reg <= ref_cnt_reg - 8'h01;
      end else begin
        std_rate_indicator <= lock_next && rate_ok;
      end
    end
  end

  // ----------------------------------------------------------------
  // output path selection
  // ----------------------------------------------------------------
  logic muted;
  logic bypass;
  assign muted = !mute_n || (mute_from_lock && !lock_indicator);
  assign bypass = force_bypass || !lock_indicator || !rate_ok;

  rclk_path_type path_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      path_reg <= RCLK_PATH_BYPASS;
    end else if (muted) begin
      path_reg <= RCLK_PATH_MUTE;
    end else if (bypass) begin
      path_reg <= RCLK_PATH_BYPASS;
    end else begin
      path_reg <= RCLK_PATH_RETIME;
    end
  end

  // serial outputs; muted legs sit static and opposite
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      primary_serial_out <= 1'b0;
      primary_serial_out_n <= 1'b1;
      aux_serial_out <= 1'b0;
      aux_serial_out_n <= 1'b1;
      selected_raw <= 1'b0;
    end else begin
      selected_raw <= chosen;
      case (path_reg)
        RCLK_PATH_MUTE: begin
          primary_serial_out <= 1'b0;
          primary_serial_out_n <= 1'b1;
          aux_serial_out <= 1'b0;
          aux_serial_out_n <= 1'b1;
        end
        RCLK_PATH_BYPASS: begin
          primary_serial_out <= chosen;
          primary_serial_out_n <= !chosen;
          aux_serial_out <= aux_clk_mode ? 1'b0 : chosen;
          aux_serial_out_n <= aux_clk_mode ? 1'b1 : !chosen;
        end
        RCLK_PATH_RETIME: begin
          primary_serial_out <= recovered_data;
          primary_serial_out_n <= !recovered_data;
          aux_serial_out <= aux_clk_mode ? recovered_clk : recovered_data;
          aux_serial_out_n <= aux_clk_mode ? !recovered_clk : !recovered_data;
        end
        default: begin
          primary_serial_out <= 1'b0;
          primary_serial_out_n <= 1'b1;
          aux_serial_out <= 1'b0;
          aux_serial_out_n <= 1'b1;
        end
      endcase
    end
  end

  // status word
  assign ctl.stat = {28'h0000000, path_reg == RCLK_PATH_MUTE, path_reg == RCLK_PATH_BYPASS,
                     std_rate_indicator, lock_indicator};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_lock_change;
    lock_indicator != $past(lock_indicator);
  endsequence

  a_force_lock_low: assert property (@(posedge aclk) disable iff (!aresetn)
    force_bypass |=> !lock_indicator)
    else $error("lock high under forced passthrough");
  a_mute_static: assert property (@(posedge aclk) disable iff (!aresetn)
    muted |=> ##1 (!primary_serial_out && primary_serial_out_n && !aux_serial_out))
    else $error("outputs not silenced");
  a_mute_over_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (muted && force_bypass) |=> path_reg == RCLK_PATH_MUTE)
    else $error("bypass beat mute");
  a_std_unlocked: assert property (@(posedge aclk) disable iff (!aresetn)
    !lock_indicator |=> ##1 !std_rate_indicator)
    else $error("standard indicator high while unlocked");
  a_std_settle: assert property (@(posedge aclk) disable iff (!aresetn)
    s_lock_change |-> !std_rate_indicator [*5])
    else $error("standard indicator changed too soon");
  a_retime_path: assert property (@(posedge aclk) disable iff (!aresetn)
    (!muted && lock_indicator && !force_bypass && rate_ok) |=> path_reg == RCLK_PATH_RETIME)
    else $error("locked but not retiming");
  a_unlock_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (!muted && !lock_indicator) |=> path_reg == RCLK_PATH_BYPASS)
    else $error("unlocked but not bypassed");
  a_aux_clk_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    (path_reg == RCLK_PATH_BYPASS && aux_clk_mode) |=> !aux_serial_out && aux_serial_out_n)
    else $error("aux clock active in bypass");
  a_sel_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> selected_raw == $past(chosen))
    else $error("selected input mismatch");

  // lock, rate, mute-from-lock and aux output checks
  a_lock_from_fsm: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_indicator |-> ($past(lk_reg) == RCLK_LK_LOCKED) && !$past(force_bypass))
    else $error("lock high without locked state");
  a_idle_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
    (idle_cnt_reg >= LOSS_CYC - 1) |=> ##1 !lock_indicator)
    else $error("lock kept after input went quiet");
  a_std_rate_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    std_rate_indicator |-> $past(rate_ok))
    else $error("standard indicator high for unsupported rate");
  a_mute_from_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    (mute_from_lock && !lock_indicator) |=> path_reg == RCLK_PATH_MUTE)
    else $error("unlocked outputs not muted");
  a_aux_clock_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (path_reg == RCLK_PATH_RETIME && aux_clk_mode) |=> aux_serial_out == $past(recovered_clk))
    else $error("aux output not carrying recovered clock");
endmodule
`default_nettype wire

// ### test/rclk_far_model.sv
// far-side model: cable equalizer on the four inputs plus the analog loop
`timescale 1ns/1ns
`default_nettype none
module rclk_far_model (
  input wire logic aclk,
  input wire logic [3:0] act,
  input wire logic loop_hint,
  input wire logic rec_level,
  output var logic [3:0] serial_in = 4'h0,
  output var logic recovered_clk = 1'b0,
  output var logic recovered_data = 1'b0,
  output var logic loop_locked = 1'b0
);
  logic [3:0] cnt_reg = 4'h0;
  logic [4:0] settle_reg = 5'h00;

  // a live channel toggles at its own rate; a dead one holds still
  always_ff @(posedge aclk) begin
    cnt_reg <= cnt_reg + 4'h1;
    for (int k = 0; k < 4; k++) begin
      if (act[k]) serial_in[k] <= cnt_reg[k];
    end
  end

  // loop clock runs only with data; lock is reported after a settle time
  always_ff @(posedge aclk) begin
    if (act != 4'h0) recovered_clk <= ~recovered_clk;
    recovered_data <= rec_level;
    settle_reg <= (act == 4'h0) ? 5'h00 : settle_reg + {4'h0, ~&settle_reg};
    loop_locked <= loop_hint && (&settle_reg);
  end
endmodule
`default_nettype wire

// ### test/reclocker_control_logic_tb.sv
// self-checking bench of the reclocker control logic
`timescale 1ns/1ns
`default_nettype none
`include "rclk_consts.svh"
module reclocker_control_logic_tb
  import rclk_pkg::*;
;
  localparam int LOSS = 50;
  localparam int ACQ = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] act = 4'h0;
  logic hint = 1'b1;
  logic rec_level = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, st;
  logic [3:0] sin;
  logic rclk, rdat, llock, lock, std, p, pn, x, xn, raw;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int tp, ta, bad;

  rclk_far_model far (.aclk(aclk), .act(act), .loop_hint(hint), .rec_level(rec_level),
    .serial_in(sin), .recovered_clk(rclk), .recovered_data(rdat), .loop_locked(llock));

  rclk_top #(.LOSS_CYC(LOSS), .ACQ_CYC(ACQ)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in_0(sin[0]), .serial_in_1(sin[1]), .serial_in_2(sin[2]), .serial_in_3(sin[3]),
    .recovered_clk(rclk), .recovered_data(rdat), .loop_locked(llock),
    .lock_indicator(lock), .std_rate_indicator(std), .primary_serial_out(p),
    .primary_serial_out_n(pn), .aux_serial_out(x), .aux_serial_out_n(xn), .selected_raw(raw));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    forever #4 aclk = ~aclk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      final_report;
    end
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    bh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ah, rh;
    logic [1:0] r;
    rh = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic ctl(input logic [1:0] s, input logic mn, f, a, m);
    wr(`RCLK_OFF_CTRL, {26'h0, m, a, f, mn, s}, `RCLK_RESP_OKAY);
  endtask

  task automatic wait_lock(input logic v, input int lim);
    for (int i = 0; i < lim && lock !== v; i++) @(negedge aclk);
    chk({31'h0, lock}, {31'h0, v});
  endtask

  // counts toggles of both outputs and cycles with equal legs
  task automatic watch;
    logic lp, la;
    tp = 0;
    ta = 0;
    bad = 0;
    repeat (4) @(negedge aclk);
    lp = p;
    la = x;
    repeat (16) begin
      @(negedge aclk);
      tp += (p !== lp);
      ta += (x !== la);
      bad += (p === pn) || (x === xn);
      lp = p;
      la = x;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults;
    rd(`RCLK_OFF_CTRL, st, `RCLK_RESP_OKAY);
    chk(st, 32'h0000_0004);
    rd(`RCLK_OFF_RATE, st, `RCLK_RESP_OKAY);
    chk(st, 32'h0000_0001);
    wr(`RCLK_OFF_STAT, 32'hFFFF_FFFF, `RCLK_RESP_OKAY);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st, 32'h0000_0004);
    rd(8'h0C, st, `RCLK_RESP_SLVERR);
    chk(st, 32'h0);
    $display("done defaults");
  endtask

  task automatic t_select;
    logic v;
    for (int k = 0; k < 4; k++) begin
      ctl(k[1:0], 1'b1, 1'b0, 1'b0, 1'b0);
      act <= 4'hF;
      repeat (3) @(negedge aclk);
      repeat (8) begin
        v = sin[k];
        @(negedge aclk);
        chk({31'h0, raw}, {31'h0, v});
      end
    end
    $display("done select");
  endtask

  task automatic t_lock;
    int i;
    wait_lock(1'b1, ACQ + 20);
    ctl(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    act <= 4'h1;
    hint <= 1'b0;
    wait_lock(1'b0, LOSS + 10);
    wait_lock(1'b1, ACQ + 20);
    chk({31'h0, std}, 32'h0);
    for (i = 0; i < 8 && std !== 1'b1; i++) @(negedge aclk);
    chk({31'h0, std}, 32'h1);
    chk(i, `RCLK_REF_CYC);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st[2:0], 3'b011);
    watch;
    chk({31'h0, p}, 32'h1);
    chk(tp, 0);
    chk(ta, 0);
    chk(bad, 0);
    ctl(2'b00, 1'b1, 1'b0, 1'b1, 1'b0);
    watch;
    chk(ta > 0, 32'h1);
    chk(tp, 0);
    $display("done lock");
  endtask

  task automatic t_force;
    ctl(2'b00, 1'b1, 1'b1, 1'b1, 1'b0);
    wait_lock(1'b0, 4);
    watch;
    chk(tp > 0, 32'h1);
    chk(ta, 0);
    chk(bad, 0);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st[2:0], 3'b100);
    ctl(2'b00, 1'b0, 1'b1, 1'b1, 1'b0);
    watch;
    chk(tp, 0);
    chk(ta, 0);
    chk(bad, 0);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st[3], 1'b1);
    ctl(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_lock(1'b1, ACQ + 20);
    $display("done force and mute");
  endtask

  task automatic t_mutelock;
    ctl(2'b00, 1'b1, 1'b0, 1'b0, 1'b1);
    act <= 4'h0;
    wait_lock(1'b0, LOSS + 10);
    chk({31'h0, std}, 32'h0);
    @(posedge aclk);
    act <= 4'h1;
    watch;
    chk(tp, 0);
    chk(ta, 0);
    wait_lock(1'b1, ACQ + 20);
    ctl(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("done mute from lock");
  endtask

  task automatic t_rate;
    wr(`RCLK_OFF_RATE, 32'h0, `RCLK_RESP_OKAY);
    repeat (8) @(negedge aclk);
    chk({31'h0, std}, 32'h0);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st[2:0], 3'b101);
    watch;
    chk(tp > 0, 32'h1);
    wr(`RCLK_OFF_RATE, 32'h1, `RCLK_RESP_OKAY);
    repeat (10) @(negedge aclk);
    rd(`RCLK_OFF_STAT, st, `RCLK_RESP_OKAY);
    chk(st[2:0], 3'b011);
    $display("done rate");
  endtask

  // main sequence: reset, scenarios, verdict
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults;
    t_select;
    t_lock;
    t_force;
    t_mutelock;
    t_rate;
    final_report;
  end
endmodule
`default_nettype wire
